// >>> design/lbp_defs.svh
`ifndef LBP_DEFS_SVH
`define LBP_DEFS_SVH

// ==========================================================
// Peripheral configuration codes
`define LBP_CFG_WIDE_ADDR   3'h0
`define LBP_CFG_NARROW_ADDR 3'h2
`define LBP_CFG_SERIAL      3'h3
`define LBP_CFG_MUXED       3'h4
`define LBP_CFG_TOP_BIT     2

// ==========================================================
// Bus clock divider codes and factors
`define LBP_DIV_CODE_2      2'h0
`define LBP_DIV_CODE_4      2'h1
`define LBP_DIV_CODE_16     2'h2
`define LBP_DIV_FACTOR_2    5'h02
`define LBP_DIV_FACTOR_4    5'h04
`define LBP_DIV_FACTOR_16   5'h10

// ==========================================================
// Shared low pin positions in serial configuration
`define LBP_SER_RESERVED    7
`define LBP_SER_SHIFT_CLK   6
`define LBP_SER_MASTER_OUT  5
`define LBP_SER_MASTER_IN   4
`define LBP_SER_SEL_HI      3
`define LBP_SER_SEL_LO      0

// ==========================================================
// Field positions and reset values
`define LBP_UPPER_HI        15
`define LBP_UPPER_LO        8
`define LBP_LOWER_HI        7
`define LBP_WORD_ALIGN_LO   2
`define LBP_ADDR_HI_LO      16
`define LBP_WORD_ALIGN_MASK 16'hfffc
`define LBP_ZERO16          16'h0000
`define LBP_ZERO32          32'h0000_0000

`endif

// >>> design/lbp_pkg.sv
package lbp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    LBP_IDLE = 4'h1,
    LBP_ADDR = 4'h2,
    LBP_DATA = 4'h4,
    LBP_END  = 4'h8
  } lbp_state_type;

  // One local bus access request
  typedef struct packed {
    logic        write;
    logic        upper;
    logic [31:0] addr;
    logic [15:0] wdata;
  } lbp_req_type;

  // Two-signal view of a shared pin group
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } lbp_pins_type;

endpackage : lbp_pkg

// >>> design/lbp_clkdiv.sv
`timescale 1ns/1ps
`include "lbp_defs.svh"

module lbp_clkdiv
  import lbp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Divider selection
  input  wire logic [1:0] bus_clock_divider,
  // Outputs
  output logic            tick,
  output logic            divided_bus_clock
);

  logic [4:0] count;
  logic [4:0] next_count;
  logic       next_clk;

  // ========================================================
  // Divider factor decode
  function automatic logic [4:0] lbp_factor(input logic [1:0] code);
    unique case (code)
      `LBP_DIV_CODE_2:  lbp_factor = `LBP_DIV_FACTOR_2;
      `LBP_DIV_CODE_4:  lbp_factor = `LBP_DIV_FACTOR_4;
      default:          lbp_factor = `LBP_DIV_FACTOR_16;
    endcase
  endfunction : lbp_factor

  // Tick on the last count of each period
  always_comb begin
    tick       = (count >= lbp_factor(bus_clock_divider) - 5'h01);
    next_count = tick ? 5'h00 : count + 5'h01;
    next_clk   = tick;
  end

  // High for one system clock per bus period
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count             <= 5'h00;
      divided_bus_clock <= 1'b0;
    end else begin
      count             <= next_count;
      divided_bus_clock <= next_clk;
    end
  end

endmodule : lbp_clkdiv

// >>> design/lbp_top.sv
`timescale 1ns/1ps
`include "lbp_defs.svh"

module lbp_top
  import lbp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic [2:0]  peripheral_config_field,
  input  wire logic        split_bus_strap,
  input  wire logic        arbiter_master_enable,
  input  wire logic [1:0]  bus_clock_divider,
  // User access port
  input  wire logic        acc_valid,
  input  lbp_req_type      acc_req,
  output logic             acc_done,
  output logic [15:0]      acc_rdata,
  // General purpose port user side
  input  wire logic [15:0] gp_out,
  input  wire logic [15:0] gp_dir,
  input  wire logic [15:0] gp_int_mask,
  output logic [15:0]      gp_in,
  output logic [15:0]      gp_change,
  // Serial control user side
  input  wire logic        serial_shift_clock_out,
  input  wire logic        serial_shift_clock_oe,
  output logic             serial_shift_clock_in,
  input  wire logic        master_out_line,
  output logic             master_in_line,
  input  wire logic [3:0]  serial_select,
  // Shared low pins
  input  wire logic [15:0] low_pins_in,
  output lbp_pins_type     low_pins,
  // Data pins
  input  wire logic [15:0] local_data_pins_in,
  output lbp_pins_type     local_data_pins,
  // Arbitration
  input  wire logic        hold_request_in,
  output logic             bus_request_out_n,
  input  wire logic        hold_status_pin_in,
  output logic             hold_status_pin_out,
  output logic             hold_status_pin_oe,
  // Strobes and selects
  output logic             peripheral_select_out_n,
  output logic             address_latch_strobe,
  output logic             address_latch_strobe_oe,
  output logic             read_strobe_out_n,
  output logic             write_strobe_out_n,
  output logic             upper_byte_enable_n,
  output logic             strobe_oe,
  input  wire logic        wait_ready_in,
  // Bus clock
  output logic             divided_bus_clock
);

  lbp_state_type state;
  lbp_state_type next_state;
  lbp_req_type   cur;
  lbp_req_type   next_cur;
  logic [15:0]   next_rdata;
  logic          next_done;
  logic          in_hold;
  logic          next_in_hold;
  logic [15:0]   gp_prev;
  logic [15:0]   next_gp_in;
  logic [15:0]   next_gp_change;
  logic          tick;
  logic          granted;
  logic          bus_master;
  logic          muxed;
  logic          data_bus;

  // ==========================================================
  // Bus clock divider
  lbp_clkdiv i_lbp_clkdiv (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .bus_clock_divider (bus_clock_divider),
    .tick              (tick),
    .divided_bus_clock (divided_bus_clock)
  );

  // ==========================================================
  // Arbitration
  // Bus is ours per hold request (arbiter) or hold status (external)
  always_comb begin
    if (arbiter_master_enable) begin
      granted = hold_request_in;
    end else begin
      granted = !hold_status_pin_in;
    end
    bus_master   = !in_hold || (state != LBP_IDLE);
    next_in_hold = (state == LBP_IDLE) ? !granted : in_hold;
  end

  // Hold status, bus request
  always_comb begin
    hold_status_pin_oe  = arbiter_master_enable;
    hold_status_pin_out = !in_hold;
    bus_request_out_n   = !(acc_valid && in_hold);
  end

  // ==========================================================
  // Access sequencer
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_rdata = acc_rdata;
    next_done  = 1'b0;
    if (tick) begin
      unique case (state)
        LBP_IDLE: begin
          if (acc_valid && !in_hold && granted) begin
            next_cur   = acc_req;
            next_state = LBP_ADDR;
          end
        end
        LBP_ADDR: next_state = LBP_DATA;
        LBP_DATA: begin
          if (!wait_ready_in) begin
            next_rdata = local_data_pins_in;
            next_state = LBP_END;
          end
        end
        LBP_END: begin
          next_done  = 1'b1;
          next_state = LBP_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state     <= LBP_IDLE;
      cur       <= '0;
      acc_rdata <= `LBP_ZERO16;
      acc_done  <= 1'b0;
      in_hold   <= 1'b1;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      acc_rdata <= next_rdata;
      acc_done  <= next_done;
      in_hold   <= next_in_hold;
    end
  end

  // ==========================================================
  // Strobes
  always_comb begin
    muxed                   = !split_bus_strap
                              && (peripheral_config_field == `LBP_CFG_MUXED);
    strobe_oe               = bus_master;
    address_latch_strobe_oe = muxed && bus_master;
    address_latch_strobe    = (state == LBP_ADDR);
    peripheral_select_out_n = (state == LBP_IDLE);
    read_strobe_out_n       = !((state == LBP_DATA) && !cur.write);
    write_strobe_out_n      = !((state == LBP_DATA) && cur.write);
    upper_byte_enable_n     = !((state != LBP_IDLE) && cur.upper);
  end

  // ==========================================================
  // Shared low pin mapping
  always_comb begin
    low_pins.out          = `LBP_ZERO16;
    low_pins.oe           = `LBP_ZERO16;
    serial_shift_clock_in = 1'b0;
    master_in_line        = 1'b0;
    if (split_bus_strap) begin
      low_pins.out = cur.addr[15:0] & `LBP_WORD_ALIGN_MASK;
      low_pins.oe  = bus_master ? `LBP_WORD_ALIGN_MASK : `LBP_ZERO16;
    end else begin
      unique case (peripheral_config_field)
        `LBP_CFG_WIDE_ADDR: begin
          low_pins.out = cur.addr[15:0];
          low_pins.oe  = {16{bus_master}};
        end
        `LBP_CFG_NARROW_ADDR: begin
          low_pins.out = {gp_out[`LBP_UPPER_HI:`LBP_UPPER_LO],
                          cur.addr[`LBP_LOWER_HI:0]};
          low_pins.oe  = {gp_dir[`LBP_UPPER_HI:`LBP_UPPER_LO], {8{bus_master}}};
        end
        `LBP_CFG_SERIAL: begin
          low_pins.out[`LBP_UPPER_HI:`LBP_UPPER_LO] =
            gp_out[`LBP_UPPER_HI:`LBP_UPPER_LO];
          low_pins.oe[`LBP_UPPER_HI:`LBP_UPPER_LO] =
            gp_dir[`LBP_UPPER_HI:`LBP_UPPER_LO];
          low_pins.out[`LBP_SER_SHIFT_CLK]  = serial_shift_clock_out;
          low_pins.oe[`LBP_SER_SHIFT_CLK]   = serial_shift_clock_oe;
          serial_shift_clock_in             = low_pins_in[`LBP_SER_SHIFT_CLK];
          low_pins.out[`LBP_SER_MASTER_OUT] = master_out_line;
          low_pins.oe[`LBP_SER_MASTER_OUT]  = 1'b1;
          master_in_line                    = low_pins_in[`LBP_SER_MASTER_IN];
          low_pins.out[`LBP_SER_SEL_HI:`LBP_SER_SEL_LO] = serial_select;
          low_pins.oe[`LBP_SER_SEL_HI:`LBP_SER_SEL_LO]  = 4'hf;
        end
        `LBP_CFG_MUXED: begin
          low_pins.out = gp_out;
          low_pins.oe  = gp_dir;
        end
        default: begin
          low_pins.out = `LBP_ZERO16;
        end
      endcase
    end
  end

  // ==========================================================
  // Data pin mapping
  always_comb begin
    data_bus            = !peripheral_config_field[`LBP_CFG_TOP_BIT];
    local_data_pins.out = cur.wdata;
    local_data_pins.oe  = `LBP_ZERO16;
    if (split_bus_strap) begin
      local_data_pins.out = cur.addr[31:`LBP_ADDR_HI_LO];
      local_data_pins.oe  = {16{bus_master}};
    end else if (muxed && state == LBP_ADDR) begin
      local_data_pins.out = cur.addr[15:0];
      local_data_pins.oe  = {16{1'b1}};
    end else if ((data_bus || muxed) && cur.write
                 && (state == LBP_DATA || state == LBP_END)) begin
      local_data_pins.oe = {16{1'b1}};
    end
  end

  // ==========================================================
  // General purpose port sampling and change flags
  always_comb begin
    next_gp_in     = low_pins_in;
    next_gp_change = (low_pins_in ^ gp_prev) & ~gp_dir & ~gp_int_mask;
    if (split_bus_strap || peripheral_config_field != `LBP_CFG_MUXED) begin
      next_gp_change = `LBP_ZERO16;
    end
  end

  // Port registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gp_prev   <= `LBP_ZERO16;
      gp_in     <= `LBP_ZERO16;
      gp_change <= `LBP_ZERO16;
    end else begin
      gp_prev   <= low_pins_in;
      gp_in     <= next_gp_in;
      gp_change <= next_gp_change;
    end
  end

endmodule : lbp_top

// >>> bench/lbp_top_props.sv
`timescale 1ns/1ps
// ==========================================
// Pin layer checker
module lbp_top_props
  import lbp_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Watched ports
  input wire logic [2:0] peripheral_config_field,
  input wire logic       split_bus_strap,
  input wire logic       arbiter_master_enable,
  input wire logic       acc_valid,
  input lbp_req_type     acc_req,
  input wire logic       wait_ready_in,
  input wire logic       hold_status_pin_in,
  input lbp_pins_type    low_pins,
  input lbp_pins_type    local_data_pins,
  input wire logic       bus_request_out_n,
  input wire logic       hold_status_pin_oe,
  input wire logic       peripheral_select_out_n,
  input wire logic       address_latch_strobe,
  input wire logic       address_latch_strobe_oe,
  input wire logic       read_strobe_out_n,
  input wire logic       write_strobe_out_n,
  input wire logic       upper_byte_enable_n,
  input wire logic       strobe_oe,
  input wire logic       divided_bus_clock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Properties
  property p_res; $past(peripheral_config_field) == 3'h3 && peripheral_config_field == 3'h3
    && !split_bus_strap |-> !low_pins.oe[7]; endproperty
  a_res: assert property (p_res) else $error("reserved pin driven");
  property p_narrow; peripheral_config_field == 3'h2 && !split_bus_strap
    && address_latch_strobe |-> low_pins.out[7:0] == acc_req.addr[7:0]; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow address wrong");
  property p_split_bus_strap; split_bus_strap && address_latch_strobe
    |-> local_data_pins.out == acc_req.addr[31:16]; endproperty
  a_split_bus_strap: assert property (p_split_bus_strap) else $error("upper address wrong");
  property p_breq; !bus_request_out_n |-> acc_valid && !strobe_oe; endproperty
  a_breq: assert property (p_breq) else $error("bus request wrong");
  property p_hold_oe; arbiter_master_enable |-> hold_status_pin_oe; endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("hold status not driven");
  property p_ext; (!arbiter_master_enable && hold_status_pin_in && peripheral_select_out_n) [*4]
    |-> !strobe_oe; endproperty
  a_ext: assert property (p_ext) else $error("bus driven in hold");
  property p_strb; !(read_strobe_out_n && write_strobe_out_n && upper_byte_enable_n)
    |-> strobe_oe; endproperty
  a_strb: assert property (p_strb) else $error("strobe active while floating");
  property p_ale; address_latch_strobe_oe
    |-> peripheral_config_field == 3'h4 && !split_bus_strap; endproperty
  a_ale: assert property (p_ale) else $error("latch strobe driven");
  property p_sel; $fell(peripheral_select_out_n) |-> address_latch_strobe; endproperty
  a_sel: assert property (p_sel) else $error("select without address");
  property p_wait; $rose(read_strobe_out_n) && strobe_oe |-> !$past(wait_ready_in); endproperty
  a_wait: assert property (p_wait) else $error("cycle ended in wait");
  property p_clk; $rose(divided_bus_clock) |=> !divided_bus_clock; endproperty
  a_clk: assert property (p_clk) else $error("bus clock high too long");
endmodule : lbp_top_props

bind lbp_top lbp_top_props i_lbp_top_props (.*);

// >>> bench/lbp_peer.sv
`timescale 1ns/1ps
// ==========================================
// Local bus target model
module lbp_peer
  import lbp_pkg::*;
(
  // Clock
  input wire logic        sys_clk,
  // Bus side
  input wire logic        sel_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [3:0]  wait_len,
  input wire logic [15:0] rd_val,
  output logic            wait_ready_in,
  output logic [15:0]     data_out
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    wait_ready_in = 1'b0;
    data_out = 16'h0000;
  end
  // Wait states from strobe start, read data only while selected
  always @(negedge sys_clk) begin
    cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
    wait_ready_in <= !(rd_n && wr_n) && (cnt < wait_len);
    data_out <= (!sel_n && !rd_n) ? rd_val : ~data_out;
  end
endmodule : lbp_peer

// >>> bench/lbp_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// Pin layer bench
module lbp_top_tb
  import lbp_pkg::*;
;
  logic [2:0] peripheral_config_field;
  logic [1:0] bus_clock_divider;
  logic [3:0] serial_select, wait_len;
  logic [15:0] acc_rdata, gp_out, gp_dir, gp_int_mask, gp_in, gp_change, low_pins_in;
  logic [15:0] local_data_pins_in, ext_low, peer_data, lp_cap, ld_cap, wd_cap;
  lbp_req_type acc_req;
  lbp_pins_type low_pins, local_data_pins;
  logic sys_clk, reset_n, split_bus_strap, arbiter_master_enable, acc_valid, acc_done;
  logic serial_shift_clock_out, serial_shift_clock_oe, serial_shift_clock_in;
  logic master_out_line, master_in_line, hold_request_in, bus_request_out_n;
  logic hold_status_pin_in, hold_status_pin_out, hold_status_pin_oe, peripheral_select_out_n;
  logic address_latch_strobe, address_latch_strobe_oe, read_strobe_out_n, write_strobe_out_n;
  logic upper_byte_enable_n, strobe_oe, wait_ready_in, divided_bus_clock, ube_seen;
  int bad_count = 0, n_tests = 0, cyc = 0, dur, d0;

  lbp_top i_lbp_top (.*);
  lbp_peer i_lbp_peer (.sys_clk(sys_clk), .sel_n(peripheral_select_out_n),
    .rd_n(read_strobe_out_n), .wr_n(write_strobe_out_n), .wait_len(wait_len),
    .rd_val(16'h9e71), .wait_ready_in(wait_ready_in), .data_out(peer_data));

  // Pin levels from all drivers
  assign low_pins_in = (low_pins.oe & low_pins.out) | (~low_pins.oe & ext_low);
  assign local_data_pins_in = (local_data_pins.oe & local_data_pins.out)
    | (~local_data_pins.oe & peer_data);
  always #2.5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk

  task access(input logic w, u, input logic [31:0] a);
    int k;
    @(negedge sys_clk);
    acc_req = '{w, u, a, 16'h5a3c};
    acc_valid = 1'b1;
    ube_seen = 1'b0;
    for (k = 0; k < 200 && acc_done !== 1'b1; k++) begin
      @(negedge sys_clk);
      if (address_latch_strobe === 1'b1) {lp_cap, ld_cap} = {low_pins.out, local_data_pins.out};
      if (upper_byte_enable_n === 1'b0) ube_seen = 1'b1;
      if (write_strobe_out_n === 1'b0) wd_cap = local_data_pins.out & local_data_pins.oe;
    end
    dur = k;
    acc_valid = 1'b0;
    chk(k < 200, 1);
  endtask : access

  task t_modes;
    access(0, 0, 32'h1234_5678);
    chk(lp_cap, 16'h5678);
    chk(acc_rdata, 16'h9e71);
    peripheral_config_field = 3'h2;
    access(0, 0, 32'h0000_00c3);
    chk(lp_cap, 16'ha5c3);
    peripheral_config_field = 3'h0;
    split_bus_strap = 1'b1;
    access(1, 0, 32'hbeef_1237);
    chk({ld_cap, lp_cap[15:2]}, {16'hbeef, 14'h048d});
    chk(low_pins.oe, 16'hfffc);
    split_bus_strap = 1'b0;
    peripheral_config_field = 3'h4;
    access(0, 0, 32'h0000_2a2a);
    chk({ld_cap, acc_rdata}, 32'h2a2a_9e71);
  endtask : t_modes

  task t_upper_wait;
    access(1, 1, 32'h10);
    chk(ube_seen, 1);
    chk(wd_cap, 16'h5a3c);
    access(1, 0, 32'h10);
    chk(ube_seen, 0);
    d0 = dur;
    wait_len = 4'h7;
    access(0, 0, 32'h20);
    chk(dur > d0 + 3, 1);
    wait_len = 4'h0;
  endtask : t_upper_wait

  task t_pins;
    gp_dir = 16'h0000;
    ext_low = 16'h0000;
    repeat (3) @(negedge sys_clk);
    ext_low = 16'h0008;
    ube_seen = 1'b0;
    repeat (4) @(negedge sys_clk) if (gp_change[3] === 1'b1) ube_seen = 1'b1;
    chk(ube_seen, 1);
    chk(gp_in, 16'h0008);
    peripheral_config_field = 3'h3;
    ext_low = 16'h0010;
    @(negedge sys_clk);
    chk({low_pins.oe[7], low_pins.out[6:5], low_pins.out[3:0], master_in_line}, 8'h35);
    peripheral_config_field = 3'h4;
    gp_dir = 16'hff00;
  endtask : t_pins

  task t_hold;
    hold_request_in = 1'b0;
    fork
      access(0, 0, 32'h44);
      begin
        repeat (8) @(negedge sys_clk);
        chk({bus_request_out_n, hold_status_pin_out, strobe_oe}, 0);
        hold_request_in = 1'b1;
      end
    join
    chk(bus_request_out_n, 1);
    arbiter_master_enable = 1'b0;
    hold_status_pin_in = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(strobe_oe, 0);
    hold_status_pin_in = 1'b0;
    access(0, 0, 32'h48);
  endtask : t_hold

  task t_clk;
    int n;
    for (int c = 0; c < 4; c++) begin
      bus_clock_divider = c[1:0];
      n = 0;
      repeat (64) @(negedge sys_clk);
      repeat (64) @(negedge sys_clk) n += divided_bus_clock;
      chk(n, (c == 0) ? 32 : (c == 1) ? 16 : 4);
    end
    bus_clock_divider = 2'h0;
  endtask : t_clk

  task conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Reset and main sequence
  initial begin
    {sys_clk, reset_n, split_bus_strap, acc_valid, serial_shift_clock_out} = 0;
    {peripheral_config_field, bus_clock_divider, wait_len, hold_status_pin_in} = 0;
    {arbiter_master_enable, hold_request_in, serial_shift_clock_oe, master_out_line} = 4'hf;
    {gp_out, gp_dir, gp_int_mask, ext_low, serial_select} = {32'ha500_ff00, 32'h0, 4'ha};
    acc_req = '0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    t_modes();
    t_upper_wait();
    t_pins();
    t_hold();
    t_clk();
    conclude();
  end
endmodule : lbp_top_tb
